/* File: shared/ifb_pkg.sv */
// Package: register map, bit positions and reset values of the interrupt flag bank two
package ifb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] IFB_FLAGS_OFFS = 12'h000;
  localparam logic [11:0] IFB_STAT_OFFS  = 12'h004;
  localparam logic [11:0] IFB_MASK_OFFS  = 12'h008;

  localparam int          IFB_WIDTH      = 16;
  localparam logic [15:0] IFB_FLAGS_RST  = 16'h0000;
  localparam logic [15:0] IFB_STAT_RST   = 16'h0000;
  localparam logic [15:0] IFB_MASK_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int TIMER_SIX_REQ_FLAG         = 15;
  localparam int DMA_CH_FOUR_DONE_FLAG      = 14;
  localparam int UNUSED_BIT                 = 13;
  localparam int OUT_CMP_EIGHT_FLAG         = 12;
  localparam int OUT_CMP_SEVEN_FLAG         = 11;
  localparam int OUT_CMP_SIX_FLAG           = 10;
  localparam int OUT_CMP_FIVE_FLAG          = 9;
  localparam int IN_CAP_SIX_FLAG            = 8;
  localparam int IN_CAP_FIVE_FLAG           = 7;
  localparam int IN_CAP_FOUR_FLAG           = 6;
  localparam int IN_CAP_THREE_FLAG          = 5;
  localparam int DMA_CH_THREE_DONE_FLAG     = 4;
  localparam int CAN_ONE_EVENT_FLAG         = 3;
  localparam int CAN_ONE_RX_READY_FLAG      = 2;
  localparam int SERIAL_PORT_TWO_EVENT_FLAG = 1;
  localparam int SERIAL_PORT_TWO_ERROR_FLAG = 0;

  // Implemented bits: all but bit 13
  localparam logic [15:0] IFB_IMPL_MASK = 16'hdfff;

endpackage

/* File: design/ifb_flag_cell.sv */
// Module: one latched interrupt flag with event set and software write
`timescale 1ns/1ps
module ifb_flag_cell (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic evtPulse,
  input  wire logic wrEn,
  input  wire logic wrVal,
  output logic      flagQ
);
  logic flag_ff;
  logic nxt_flag;

  // A peripheral event in the write cycle still wins, so no request is lost
  always_comb begin
    nxt_flag = flag_ff;
    if (wrEn) begin
      nxt_flag = wrVal;
    end
    if (evtPulse) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flagQ = flag_ff;

  a_flag_event_sets : assert property (@(posedge clk) disable iff (rst)
    evtPulse |=> flag_ff)
    else $error("flag not set after event");

  a_flag_no_spur : assert property (@(posedge clk) disable iff (rst)
    (!flag_ff && !evtPulse && !(wrEn && wrVal)) |=> !flag_ff)
    else $error("flag set without event or write");

  a_flag_holds : assert property (@(posedge clk) disable iff (rst)
    (flag_ff && !wrEn) |=> flag_ff)
    else $error("flag lost without clear");
endmodule

/* File: design/ifb_flag_bank.sv */
// Module: interrupt flag bank two with APB slave, sticky status, mask and interrupt
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ifb_flag_bank
  import ifb_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [ifb_pkg::IFB_WIDTH-1:0] evtIn,
  output logic      [ifb_pkg::IFB_WIDTH-1:0] flagsOut,
  output logic                               irq
);
  import ifb_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        access;
  logic        wrAcc;
  logic        rdAcc;
  logic        hitFlags;
  logic        hitStat;
  logic        hitMask;
  logic        unmapped;
  logic [15:0] wrMask;

  assign access   = psel && penable;
  assign wrAcc    = access && pwrite;
  assign rdAcc    = access && !pwrite;
  assign hitFlags = (paddr == IFB_FLAGS_OFFS);
  assign hitStat  = (paddr == IFB_STAT_OFFS);
  assign hitMask  = (paddr == IFB_MASK_OFFS);
  assign unmapped = !(hitFlags || hitStat || hitMask);
  // Only the low two lanes hold the 16-bit register
  assign wrMask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // Zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign pslverr  = access && unmapped;

  // ----------------------------------------------------------------
  // Flag cells
  // ----------------------------------------------------------------
  logic [15:0] flagQ;
  logic [15:0] evtGated;

  genvar gi;
  generate
    for (gi = 0; gi < IFB_WIDTH; gi++) begin : g_flag
      if (IFB_IMPL_MASK[gi]) begin : g_impl
        ifb_flag_cell u_cell (
          .clk      (clk),
          .rst      (rst),
          .evtPulse (evtIn[gi]),
          .wrEn     (wrAcc && hitFlags && wrMask[gi]),
          .wrVal    (pwdata[gi]),
          .flagQ    (flagQ[gi])
        );
        assign evtGated[gi] = evtIn[gi];
      end else begin : g_none
        assign flagQ[gi]    = 1'b0;
        assign evtGated[gi] = 1'b0;
      end
    end
  endgenerate

  assign flagsOut = flagQ;

  // ----------------------------------------------------------------
  // Sticky status, mask, read data
  // ----------------------------------------------------------------
  logic [15:0] stat_ff;
  logic [15:0] mask_ff;
  logic [31:0] rdata_ff;
  logic [15:0] nxt_stat;
  logic [15:0] nxt_mask;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_stat  = stat_ff;
    nxt_mask  = mask_ff;
    nxt_rdata = rdata_ff;
    if (rdAcc && hitStat) begin
      nxt_stat = '0;
    end
    // Events arriving during the clearing read are kept
    nxt_stat = nxt_stat | evtGated;
    if (wrAcc && hitMask) begin
      nxt_mask = ((mask_ff & ~wrMask) | (pwdata[15:0] & wrMask)) & IFB_IMPL_MASK;
    end
    if (psel && !penable && !pwrite) begin
      unique case (1'b1)
        (paddr == IFB_FLAGS_OFFS): nxt_rdata = {16'h0000, flagQ};
        (paddr == IFB_STAT_OFFS):  nxt_rdata = {16'h0000, stat_ff | evtGated};
        (paddr == IFB_MASK_OFFS):  nxt_rdata = {16'h0000, mask_ff};
        default:                   nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff  <= IFB_STAT_RST;
      mask_ff  <= IFB_MASK_RST;
      rdata_ff <= 32'h0000_0000;
    end else begin
      stat_ff  <= nxt_stat;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop
  assign prdata = rdata_ff;
  assign irq    = |(stat_ff & mask_ff);

  a_unimpl_zero : assert property (@(posedge clk) disable iff (rst)
    !flagsOut[UNUSED_BIT] && !mask_ff[UNUSED_BIT] && !stat_ff[UNUSED_BIT])
    else $error("unimplemented bit reads one");

  a_event_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[OUT_CMP_EIGHT_FLAG] |=> flagsOut[OUT_CMP_EIGHT_FLAG])
    else $error("compare eight flag missed");

  a_timer_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[TIMER_SIX_REQ_FLAG] |=> flagsOut[TIMER_SIX_REQ_FLAG])
    else $error("timer six flag missed");

  a_rx_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[CAN_ONE_RX_READY_FLAG] |=> flagsOut[CAN_ONE_RX_READY_FLAG])
    else $error("receive ready flag missed");

  a_spi_err_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[SERIAL_PORT_TWO_ERROR_FLAG] |=> flagsOut[SERIAL_PORT_TWO_ERROR_FLAG])
    else $error("serial error flag missed");

  a_write_clears : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && pstrb[0] && !pwdata[0] && !evtIn[0]) |=> !flagsOut[0])
    else $error("write zero did not clear flag");

  a_read_flags : assert property (@(posedge clk) disable iff (rst)
    (psel && !penable && !pwrite && hitFlags) |=> (prdata[15:0] == $past(flagsOut)))
    else $error("flag read data wrong");

  a_no_spur_set : assert property (@(posedge clk) disable iff (rst)
    (!flagsOut[3] && !evtIn[3] && !(wrAcc && hitFlags)) |=> !flagsOut[3])
    else $error("flag set without cause");

  a_irq_level : assert property (@(posedge clk) disable iff (rst)
    (|(evtGated & mask_ff) && !(wrAcc && hitMask)) |=> irq)
    else $error("unmasked event did not raise interrupt");

  // ----------------------------------------------------------------
  // Per-flag event latching
  // ----------------------------------------------------------------
  a_dma_four_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[DMA_CH_FOUR_DONE_FLAG] |=> flagsOut[DMA_CH_FOUR_DONE_FLAG])
    else $error("dma four flag missed");

  a_cmp_seven_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[OUT_CMP_SEVEN_FLAG] |=> flagsOut[OUT_CMP_SEVEN_FLAG])
    else $error("compare seven flag missed");

  a_cmp_six_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[OUT_CMP_SIX_FLAG] |=> flagsOut[OUT_CMP_SIX_FLAG])
    else $error("compare six flag missed");

  a_cmp_five_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[OUT_CMP_FIVE_FLAG] |=> flagsOut[OUT_CMP_FIVE_FLAG])
    else $error("compare five flag missed");

  a_cap_six_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[IN_CAP_SIX_FLAG] |=> flagsOut[IN_CAP_SIX_FLAG])
    else $error("capture six flag missed");

  a_cap_five_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[IN_CAP_FIVE_FLAG] |=> flagsOut[IN_CAP_FIVE_FLAG])
    else $error("capture five flag missed");

  a_cap_four_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[IN_CAP_FOUR_FLAG] |=> flagsOut[IN_CAP_FOUR_FLAG])
    else $error("capture four flag missed");

  a_cap_three_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[IN_CAP_THREE_FLAG] |=> flagsOut[IN_CAP_THREE_FLAG])
    else $error("capture three flag missed");

  a_dma_three_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[DMA_CH_THREE_DONE_FLAG] |=> flagsOut[DMA_CH_THREE_DONE_FLAG])
    else $error("dma three flag missed");

  a_can_evt_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[CAN_ONE_EVENT_FLAG] |=> flagsOut[CAN_ONE_EVENT_FLAG])
    else $error("controller event flag missed");

  a_spi_evt_latched : assert property (@(posedge clk) disable iff (rst)
    evtIn[SERIAL_PORT_TWO_EVENT_FLAG] |=> flagsOut[SERIAL_PORT_TWO_EVENT_FLAG])
    else $error("serial event flag missed");

  // ----------------------------------------------------------------
  // Software writes to the flags
  // ----------------------------------------------------------------
  a_write_sets : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && pstrb[0] && pwdata[0]) |=> flagsOut[0])
    else $error("write one did not set flag");

  a_write_clears_hi : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && pstrb[1] && !pwdata[15] && !evtIn[15]) |=> !flagsOut[15])
    else $error("write zero did not clear upper flag");

  a_lane_lo_kept : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && !pstrb[0]) |=> flagsOut[7:0] == $past(flagsOut[7:0] | evtGated[7:0]))
    else $error("disabled low lane changed flags");

  a_lane_hi_kept : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && !pstrb[1]) |=> flagsOut[15:8] == $past(flagsOut[15:8] | evtGated[15:8]))
    else $error("disabled high lane changed flags");

  a_write_value : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && &pstrb[1:0] && !(|evtIn))
      |=> flagsOut == ($past(pwdata[15:0]) & IFB_IMPL_MASK))
    else $error("flag write value not taken");

  a_bad_addr_wr : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && unmapped && !(|evtIn))
      |=> (flagsOut == $past(flagsOut)) && (mask_ff == $past(mask_ff)))
    else $error("unmapped write changed a register");

  a_flags_idle : assert property (@(posedge clk) disable iff (rst)
    (!wrAcc && !(|evtIn)) |=> flagsOut == $past(flagsOut))
    else $error("flags changed without event or write");

  a_flag_no_status : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && !(|evtIn)) |=> stat_ff == $past(stat_ff))
    else $error("flag write changed status");

  a_evt_wins_clr : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitFlags && pstrb[0] && evtIn[0]) |=> flagsOut[0])
    else $error("clear in event cycle lost the event");

  a_bit13_write : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && (hitFlags || hitMask) && pwdata[UNUSED_BIT]) |=> !mask_ff[UNUSED_BIT])
    else $error("unimplemented bit took a write");

  // ----------------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------------
  a_stat_read_clr : assert property (@(posedge clk) disable iff (rst)
    (rdAcc && hitStat && !(|evtGated)) |=> stat_ff == 16'h0000)
    else $error("status read did not clear");

  a_stat_keeps_evt : assert property (@(posedge clk) disable iff (rst)
    (rdAcc && hitStat) |=> stat_ff == $past(evtGated))
    else $error("event lost in status read cycle");

  a_stat_sticky : assert property (@(posedge clk) disable iff (rst)
    !(rdAcc && hitStat) |=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
    else $error("status bit lost without read");

  a_stat_sets : assert property (@(posedge clk) disable iff (rst)
    (|evtGated) |=> (stat_ff & $past(evtGated)) == $past(evtGated))
    else $error("event did not set status");

  a_mask_write : assert property (@(posedge clk) disable iff (rst)
    (wrAcc && hitMask && &pstrb[1:0]) |=> mask_ff == ($past(pwdata[15:0]) & IFB_IMPL_MASK))
    else $error("mask write not taken");

  a_mask_holds : assert property (@(posedge clk) disable iff (rst)
    !(wrAcc && hitMask) |=> mask_ff == $past(mask_ff))
    else $error("mask changed without write");

  a_irq_drop : assert property (@(posedge clk) disable iff (rst)
    (rdAcc && hitStat && !(|evtGated)) |=> !irq)
    else $error("interrupt stayed after status read");

  a_irq_masked : assert property (@(posedge clk) disable iff (rst)
    (mask_ff == 16'h0000 && !(wrAcc && hitMask)) |=> !irq)
    else $error("interrupt raised while fully masked");

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  a_bad_rdata : assert property (@(posedge clk) disable iff (rst)
    (psel && !penable && !pwrite && unmapped) |=> prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");

  a_read_stat : assert property (@(posedge clk) disable iff (rst)
    (psel && !penable && !pwrite && hitStat) |=> prdata[15:0] == $past(stat_ff | evtGated))
    else $error("status read data wrong");

  a_read_mask : assert property (@(posedge clk) disable iff (rst)
    (psel && !penable && !pwrite && hitMask) |=> prdata[15:0] == $past(mask_ff))
    else $error("mask read data wrong");

  a_rdata_upper : assert property (@(posedge clk) disable iff (rst)
    prdata[31:16] == 16'h0000)
    else $error("upper read lanes not zero");

  a_rdata_stable : assert property (@(posedge clk) disable iff (rst)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read setup");
endmodule

/* File: tb/tb_top.sv */
// Testbench: flag bank two against a reference model, driven over APB
`timescale 1ns/1ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import ifb_pkg::*;
  logic        clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] evtIn = 16'h0;
  logic [15:0] flagsOut;
  logic        irq;
  logic [31:0] seed = 32'h3aa3;
  int          mismatches = 0;
  int          totalChecks = 0;
  int          flg = 0;
  int          st = 0;
  int          msk = 0;
  int          ln = 0;

  always #25 clk = ~clk;

  ifb_flag_bank u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evtIn(evtIn), .flagsOut(flagsOut), .irq(irq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task stop_test;
    if (mismatches == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus and event drivers
  // ----------------------------------------------------------------
  // The leading edge keeps a release and the next setup out of one time step
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d,
           output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 16'h0, q, e);
    `CHK(q, exp)
    `CHK(e, 1'(a > 12'h008))
  endtask

  task wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // Irq follows the registered status and mask, so look on the second falling edge after the event edge
  task chkOut;
    repeat (2) @(negedge clk);
    `CHK(flagsOut, flg[15:0])
    `CHK(irq, 1'((st & msk) != 0))
  endtask

  task pulse(input logic [15:0] m);
    @(posedge clk);
    evtIn <= m;
    @(posedge clk);
    evtIn <= 16'h0;
    flg = flg | (m & 16'hdfff);
    st = st | (m & 16'hdfff);
    chkOut();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(IFB_FLAGS_OFFS, 32'h0);
    rdchk(IFB_MASK_OFFS, 32'h0);
    for (int i = 0; i < 16; i++) begin
      pulse(16'h1 << i);
      rdchk(IFB_FLAGS_OFFS, flg);
      chkOut();
      wr(IFB_FLAGS_OFFS, 16'h0);
      flg = 0;
      rdchk(IFB_FLAGS_OFFS, flg);
    end
    wr(IFB_FLAGS_OFFS, 16'hffff);
    flg = 16'hdfff;
    rdchk(IFB_FLAGS_OFFS, flg);
    rdchk(IFB_STAT_OFFS, st);
    st = 0;
    rdchk(12'h00c, 32'h0);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      pulse(seed[15:0] & seed[31:16]);
      // Random byte lanes exercise the strobe gating of both writable registers
      @(posedge clk);
      pstrb <= seed[13:10];
      ln = {16'h0000, {8{seed[11]}}, {8{seed[10]}}};
      if (seed[5]) begin
        wr(IFB_MASK_OFFS, seed[31:16]);
        msk = ((msk & ~ln) | (seed[31:16] & ln)) & 16'hdfff;
      end
      if (seed[9]) begin
        wr(IFB_FLAGS_OFFS, seed[15:0]);
        flg = ((flg & ~ln) | (seed[15:0] & ln)) & 16'hdfff;
      end
      chkOut();
      rdchk(IFB_MASK_OFFS, msk);
      rdchk(IFB_STAT_OFFS, st);
      st = 0;
      chkOut();
    end
    stop_test();
  end

  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
